// ### css_cfg.svh
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH

// ------------------------------------------------------------------
// Addressing and verb codes
// ------------------------------------------------------------------
`define CSS_NODE_ID 8'h14
`define CSS_VERB_GET_PARAM 12'hF00
`define CSS_VERB_GET_SEL 12'hF01
`define CSS_VERB_GET_LIST 12'hF02
`define CSS_VERB_GET_PWR 12'hF05
`define CSS_VERB_GET_SWAP 12'hF0C
`define CSS_VERB_SET_SEL 12'h701
`define CSS_VERB_SET_PWR 12'h705
`define CSS_VERB_SET_SWAP 12'h70C
`define CSS_VERB_SET_AMP 4'h3
`define CSS_VERB_GET_AMP 4'hB
`define CSS_PARAM_WIDGET_CAPABILITIES 8'h09
`define CSS_PARAM_LIST_LEN 8'h0E
`define CSS_PARAM_AMP_CAPS 8'h12
`define CSS_LIST_OFS_LOWER 8'h00
`define CSS_LIST_OFS_UPPER 8'h04

// ------------------------------------------------------------------
// Fixed parameter words
// ------------------------------------------------------------------
`define CSS_WIDGET_CAPABILITIES_TYPE 4'h3
`define CSS_WIDGET_CAPABILITIES_DELAY 4'h0
`define CSS_WIDGET_CAPABILITIES_FLAGS 12'hD0D
`define CSS_WIDGET_CAPABILITIES_VALUE {8'h00, `CSS_WIDGET_CAPABILITIES_TYPE, `CSS_WIDGET_CAPABILITIES_DELAY, 4'h0, `CSS_WIDGET_CAPABILITIES_FLAGS}
`define CSS_LIST_LONG_FORM 1'b0
`define CSS_SRC_COUNT 7'h05
`define CSS_LIST_LEN_VALUE {24'h00_0000, `CSS_LIST_LONG_FORM, `CSS_SRC_COUNT}
`define CSS_SRC0_NID 8'h16
`define CSS_SRC1_NID 8'h10
`define CSS_SRC2_NID 8'h11
`define CSS_SRC3_NID 8'h0E
`define CSS_SRC4_NID 8'h0F
`define CSS_NO_SOURCE 8'h00
`define CSS_LIST_LOWER_VALUE {`CSS_SRC3_NID, `CSS_SRC2_NID, `CSS_SRC1_NID, `CSS_SRC0_NID}
`define CSS_LIST_UPPER_VALUE {24'h00_0000, `CSS_SRC4_NID}
`define CSS_AMP_MUTE_CAP 1'b1
`define CSS_AMP_STEP_CODE 7'h03
`define CSS_AMP_NUM_STEPS 7'h2E
`define CSS_AMP_ZERO_DB 7'h10
`define CSS_AMP_CAPS_VALUE {`CSS_AMP_MUTE_CAP, 8'h00, `CSS_AMP_STEP_CODE, 1'b0, `CSS_AMP_NUM_STEPS, 1'b0, `CSS_AMP_ZERO_DB}

// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define CSS_AMP_OUT_BIT 15
`define CSS_AMP_LEFT_BIT 13
`define CSS_AMP_RIGHT_BIT 12
`define CSS_AMP_MUTE_BIT 7
`define CSS_AMP_GAIN_MSB 5
`define CSS_AMP_MUTE_RST 1'b1
`define CSS_AMP_GAIN_RST 6'h10
`define CSS_SEL_MSB 2
`define CSS_SEL_RST 3'h0
`define CSS_PWR_LOST_BIT 10
`define CSS_PWR_ERR_BIT 8
`define CSS_PWR_ACT_LSB 4
`define CSS_PWR_SET_MSB 1
`define CSS_PWR_SET_RST 2'h0
`define CSS_PWR_ACT_RST 2'h3
`define CSS_SWAP_BIT 2
`define CSS_SWAP_RST 1'b0

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define CSS_CLK_NS 8
`define CSS_PWR_SETTLE_NS 80
`define CSS_PWR_SETTLE_CYC ((`CSS_PWR_SETTLE_NS + `CSS_CLK_NS - 1) / `CSS_CLK_NS)

`endif

// ### css_pkg.sv
package css_pkg;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    CSS_CMD_NONE,
    CSS_CMD_GET_PARAM,
    CSS_CMD_GET_SEL,
    CSS_CMD_GET_LIST,
    CSS_CMD_GET_PWR,
    CSS_CMD_GET_SWAP,
    CSS_CMD_GET_AMP,
    CSS_CMD_SET_SEL,
    CSS_CMD_SET_PWR,
    CSS_CMD_SET_SWAP,
    CSS_CMD_SET_AMP
  } css_cmd_t;

  typedef enum logic [1:0] {
    CSS_PS_IDLE = 2'b01,
    CSS_PS_SETTLE = 2'b10
  } css_pwr_fsm_t;

  typedef logic [1:0] css_pstate_t;

  // Every write verb counts as an access that clears the settings-lost flag.
  function automatic logic css_is_set(input css_cmd_t cmd);
    css_is_set = (cmd == CSS_CMD_SET_SEL) || (cmd == CSS_CMD_SET_PWR) ||
                 (cmd == CSS_CMD_SET_SWAP) || (cmd == CSS_CMD_SET_AMP);
  endfunction : css_is_set

endpackage : css_pkg

// ### css_verb_decode.sv
`timescale 1ns/1ps
`include "css_cfg.svh"

module css_verb_decode
  import css_pkg::*;
(
  input wire logic [7:0] verb_nid,
  input wire logic [19:0] verb_word,
  output logic hit,
  output css_cmd_t cmd
);

  always_comb begin
    hit = (verb_nid == `CSS_NODE_ID);
    cmd = CSS_CMD_NONE;
    if (verb_word[19:16] == `CSS_VERB_SET_AMP) begin
      cmd = CSS_CMD_SET_AMP;
    end else if (verb_word[19:16] == `CSS_VERB_GET_AMP) begin
      cmd = CSS_CMD_GET_AMP;
    end else begin
      case (verb_word[19:8])
        `CSS_VERB_GET_PARAM: cmd = CSS_CMD_GET_PARAM;
        `CSS_VERB_GET_SEL: cmd = CSS_CMD_GET_SEL;
        `CSS_VERB_GET_LIST: cmd = CSS_CMD_GET_LIST;
        `CSS_VERB_GET_PWR: cmd = CSS_CMD_GET_PWR;
        `CSS_VERB_GET_SWAP: cmd = CSS_CMD_GET_SWAP;
        `CSS_VERB_SET_SEL: cmd = CSS_CMD_SET_SEL;
        `CSS_VERB_SET_PWR: cmd = CSS_CMD_SET_PWR;
        `CSS_VERB_SET_SWAP: cmd = CSS_CMD_SET_SWAP;
        default: cmd = CSS_CMD_NONE;
      endcase
    end
  end

endmodule : css_verb_decode

// ### css_power_seq.sv
`timescale 1ns/1ps
`include "css_cfg.svh"

module css_power_seq
  import css_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire css_pstate_t set_state,
  input wire css_pstate_t floor_state,
  output css_pstate_t act_state_ff,
  output logic err_ff,
  output logic busy_ff
);

  localparam logic [3:0] SETTLE_CYC = 4'(`CSS_PWR_SETTLE_CYC);

  css_pwr_fsm_t fsm_ff;
  css_pstate_t target_ff;
  logic [3:0] cnt_ff;
  css_pstate_t nxt_target;

  // The widget can never be more awake than its function group allows.
  always_comb begin
    nxt_target = (set_state < floor_state) ? floor_state : set_state;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= (set_state < floor_state);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fsm_ff <= CSS_PS_IDLE;
      cnt_ff <= 4'h0;
      target_ff <= `CSS_PWR_ACT_RST;
      act_state_ff <= `CSS_PWR_ACT_RST;
      busy_ff <= 1'b0;
    end else begin
      case (fsm_ff)
        CSS_PS_IDLE: begin
          if (nxt_target != act_state_ff) begin
            fsm_ff <= CSS_PS_SETTLE;
            target_ff <= nxt_target;
            cnt_ff <= SETTLE_CYC;
            busy_ff <= 1'b1;
          end
        end
        CSS_PS_SETTLE: begin
          if (cnt_ff == 4'h1) begin
            act_state_ff <= target_ff;
            fsm_ff <= CSS_PS_IDLE;
            busy_ff <= 1'b0;
          end
          cnt_ff <= cnt_ff - 4'h1;
        end
        default: begin
          fsm_ff <= CSS_PS_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

endmodule : css_power_seq

// ### css_selector_regs.sv
`timescale 1ns/1ps
`include "css_cfg.svh"

module css_selector_regs
  import css_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic verb_valid,
  input wire logic [7:0] verb_nid,
  input wire logic [19:0] verb_word,
  input wire logic [1:0] pwr_floor,
  output logic resp_valid_ff,
  output logic [31:0] resp_data_ff,
  output logic [7:0] src_nid_ff,
  output logic src_valid_ff,
  output logic path_left_mute_ff,
  output logic [5:0] path_left_gain_ff,
  output logic path_right_mute_ff,
  output logic [5:0] path_right_gain_ff,
  output logic [1:0] pwr_act_ff,
  output logic pwr_busy_ff
);

  // ------------------------------------------------------------------
  // Verb decode
  // ------------------------------------------------------------------
  logic hit;
  css_cmd_t cmd;
  logic take;
  logic [7:0] payload8;
  logic [15:0] payload16;

  css_verb_decode u_decode (
    .verb_nid(verb_nid),
    .verb_word(verb_word),
    .hit(hit),
    .cmd(cmd)
  );

  assign take = verb_valid && hit;
  assign payload8 = verb_word[7:0];
  assign payload16 = verb_word[15:0];

  // ------------------------------------------------------------------
  // Output amplifier controls, index 0 is left and 1 is right
  // ------------------------------------------------------------------
  logic amp_mute_ff [2];
  logic [5:0] amp_gain_ff [2];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_amp
      localparam int SEL_BIT = (ch == 0) ? `CSS_AMP_LEFT_BIT : `CSS_AMP_RIGHT_BIT;
      // Writes aimed only at the absent input amplifier are ignored.
      always_ff @(posedge mclk) begin
        if (rst) begin
          amp_mute_ff[ch] <= `CSS_AMP_MUTE_RST;
          amp_gain_ff[ch] <= `CSS_AMP_GAIN_RST;
        end else if (take && cmd == CSS_CMD_SET_AMP && payload16[`CSS_AMP_OUT_BIT] && payload16[SEL_BIT]) begin
          amp_mute_ff[ch] <= payload16[`CSS_AMP_MUTE_BIT];
          amp_gain_ff[ch] <= payload16[`CSS_AMP_GAIN_MSB:0];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Source select, swap and requested power state
  // ------------------------------------------------------------------
  logic [2:0] sel_ff;
  logic swap_ff;
  css_pstate_t pset_ff;
  logic lost_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_ff <= `CSS_SEL_RST;
    end else if (take && cmd == CSS_CMD_SET_SEL) begin
      sel_ff <= payload8[`CSS_SEL_MSB:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      swap_ff <= `CSS_SWAP_RST;
    end else if (take && cmd == CSS_CMD_SET_SWAP) begin
      swap_ff <= payload8[`CSS_SWAP_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pset_ff <= `CSS_PWR_SET_RST;
    end else if (take && cmd == CSS_CMD_SET_PWR) begin
      pset_ff <= payload8[`CSS_PWR_SET_MSB:0];
    end
  end

  // Only reset sets this flag, so no access can race a set.
  always_ff @(posedge mclk) begin
    if (rst) begin
      lost_ff <= 1'b1;
    end else if (take && (cmd == CSS_CMD_GET_PWR || css_is_set(cmd))) begin
      lost_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Power sequencing
  // ------------------------------------------------------------------
  logic pwr_err;

  css_power_seq u_power (
    .mclk(mclk),
    .rst(rst),
    .set_state(pset_ff),
    .floor_state(pwr_floor),
    .act_state_ff(pwr_act_ff),
    .err_ff(pwr_err),
    .busy_ff(pwr_busy_ff)
  );

  // ------------------------------------------------------------------
  // Audio path controls
  // ------------------------------------------------------------------
  logic [7:0] nxt_src_nid;

  always_comb begin
    case (sel_ff)
      3'h0: nxt_src_nid = `CSS_SRC0_NID;
      3'h1: nxt_src_nid = `CSS_SRC1_NID;
      3'h2: nxt_src_nid = `CSS_SRC2_NID;
      3'h3: nxt_src_nid = `CSS_SRC3_NID;
      3'h4: nxt_src_nid = `CSS_SRC4_NID;
      default: nxt_src_nid = `CSS_NO_SOURCE;
    endcase
  end

  // An out-of-range index drops the route rather than aliasing onto a real input.
  always_ff @(posedge mclk) begin
    if (rst) begin
      src_nid_ff <= `CSS_SRC0_NID;
      src_valid_ff <= 1'b1;
    end else begin
      src_nid_ff <= nxt_src_nid;
      src_valid_ff <= ({4'h0, sel_ff} < `CSS_SRC_COUNT);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      path_left_mute_ff <= `CSS_AMP_MUTE_RST;
      path_left_gain_ff <= `CSS_AMP_GAIN_RST;
      path_right_mute_ff <= `CSS_AMP_MUTE_RST;
      path_right_gain_ff <= `CSS_AMP_GAIN_RST;
    end else begin
      path_left_mute_ff <= swap_ff ? amp_mute_ff[1] : amp_mute_ff[0];
      path_left_gain_ff <= swap_ff ? amp_gain_ff[1] : amp_gain_ff[0];
      path_right_mute_ff <= swap_ff ? amp_mute_ff[0] : amp_mute_ff[1];
      path_right_gain_ff <= swap_ff ? amp_gain_ff[0] : amp_gain_ff[1];
    end
  end

  // ------------------------------------------------------------------
  // Responses
  // ------------------------------------------------------------------
  logic [31:0] nxt_resp_data;
  logic amp_ch;

  assign amp_ch = !payload16[`CSS_AMP_LEFT_BIT];

  always_comb begin
    nxt_resp_data = 32'h0000_0000;
    case (cmd)
      CSS_CMD_GET_PARAM: begin
        if (payload8 == `CSS_PARAM_WIDGET_CAPABILITIES) begin
          nxt_resp_data = `CSS_WIDGET_CAPABILITIES_VALUE;
        end else if (payload8 == `CSS_PARAM_LIST_LEN) begin
          nxt_resp_data = `CSS_LIST_LEN_VALUE;
        end else if (payload8 == `CSS_PARAM_AMP_CAPS) begin
          nxt_resp_data = `CSS_AMP_CAPS_VALUE;
        end
      end
      CSS_CMD_GET_LIST: begin
        if (payload8 == `CSS_LIST_OFS_LOWER) begin
          nxt_resp_data = `CSS_LIST_LOWER_VALUE;
        end else if (payload8 == `CSS_LIST_OFS_UPPER) begin
          nxt_resp_data = `CSS_LIST_UPPER_VALUE;
        end
      end
      CSS_CMD_GET_AMP: begin
        if (payload16[`CSS_AMP_OUT_BIT]) begin
          nxt_resp_data[`CSS_AMP_MUTE_BIT] = amp_mute_ff[amp_ch];
          nxt_resp_data[`CSS_AMP_GAIN_MSB:0] = amp_gain_ff[amp_ch];
        end
      end
      CSS_CMD_GET_SEL: begin
        nxt_resp_data[`CSS_SEL_MSB:0] = sel_ff;
      end
      CSS_CMD_GET_PWR: begin
        nxt_resp_data[`CSS_PWR_LOST_BIT] = lost_ff;
        nxt_resp_data[`CSS_PWR_ERR_BIT] = pwr_err;
        nxt_resp_data[`CSS_PWR_ACT_LSB +: 2] = pwr_act_ff;
        nxt_resp_data[`CSS_PWR_SET_MSB:0] = pset_ff;
      end
      CSS_CMD_GET_SWAP: begin
        nxt_resp_data[`CSS_SWAP_BIT] = swap_ff;
      end
      default: begin
        nxt_resp_data = 32'h0000_0000;
      end
    endcase
  end

  // Every verb to this node, known or not, gets exactly one response word.
  always_ff @(posedge mclk) begin
    if (rst) begin
      resp_valid_ff <= 1'b0;
      resp_data_ff <= 32'h0000_0000;
    end else begin
      resp_valid_ff <= take;
      resp_data_ff <= take ? nxt_resp_data : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence param_read(logic [7:0] id);
    take && cmd == CSS_CMD_GET_PARAM && payload8 == id;
  endsequence

  sequence list_read(logic [7:0] ofs);
    take && cmd == CSS_CMD_GET_LIST && payload8 == ofs;
  endsequence

  sequence pwr_read;
    take && cmd == CSS_CMD_GET_PWR;
  endsequence

  sequence left_amp_write;
    take && cmd == CSS_CMD_SET_AMP && payload16[`CSS_AMP_OUT_BIT] && payload16[`CSS_AMP_LEFT_BIT];
  endsequence

  foreign_node_a: assert property (verb_valid && verb_nid != `CSS_NODE_ID |=> !resp_valid_ff)
    else $error("response given to a verb for another node");

  caps_word_a: assert property (param_read(`CSS_PARAM_WIDGET_CAPABILITIES) |=> resp_valid_ff &&
    resp_data_ff[23:20] == `CSS_WIDGET_CAPABILITIES_TYPE && resp_data_ff[19:16] == `CSS_WIDGET_CAPABILITIES_DELAY &&
    resp_data_ff[11] && resp_data_ff[9:4] == 6'h10 && resp_data_ff[1] == 1'b0)
    else $error("capability word is wrong");

  list_len_a: assert property (param_read(`CSS_PARAM_LIST_LEN) |=> resp_valid_ff &&
    resp_data_ff[6:0] == `CSS_SRC_COUNT && !resp_data_ff[7])
    else $error("source list length word is wrong");

  list_lower_a: assert property (list_read(`CSS_LIST_OFS_LOWER) |=> resp_data_ff == 32'h0E11_1016)
    else $error("lower source list word is wrong");

  list_upper_a: assert property (list_read(`CSS_LIST_OFS_UPPER) |=> resp_data_ff == 32'h0000_000F)
    else $error("upper source list word is wrong");

  amp_caps_a: assert property (param_read(`CSS_PARAM_AMP_CAPS) |=> resp_data_ff[31] &&
    resp_data_ff[22:16] == `CSS_AMP_STEP_CODE && resp_data_ff[14:8] == `CSS_AMP_NUM_STEPS &&
    resp_data_ff[6:0] == `CSS_AMP_ZERO_DB)
    else $error("gain capability word is wrong");

  amp_write_a: assert property (left_amp_write |=> amp_mute_ff[0] == $past(payload16[7]) &&
    amp_gain_ff[0] == $past(payload16[5:0]) ##1 path_left_gain_ff == (swap_ff ? amp_gain_ff[1] : $past(amp_gain_ff[0])))
    else $error("left gain write not taken");

  no_source_a: assert property (sel_ff > 3'h4 |=> !src_valid_ff && src_nid_ff == `CSS_NO_SOURCE)
    else $error("out of range index still routes a source");

  lost_clear_a: assert property (pwr_read |=> resp_data_ff[10] == $past(lost_ff) ##0 !lost_ff [*2])
    else $error("settings-lost flag not cleared by a read");

  // Only a power state read carries the error bit; of the other replies to this node, only the capability word has bit 8 set.
  pwr_error_a: assert property ((pset_ff < pwr_floor) [*2] |->
    pwr_err ##1 (resp_data_ff[8] || !$past(take && cmd == CSS_CMD_GET_PWR)))
    else $error("refused power state does not show the error bit");

  act_settle_a: assert property ($changed(pwr_act_ff) |-> $past(pwr_busy_ff))
    else $error("actual power state moved without settling");

  pset_store_a: assert property (take && cmd == CSS_CMD_SET_PWR |=> pset_ff == $past(payload8[1:0]))
    else $error("power request not stored");

  swap_path_a: assert property (swap_ff ##1 $stable(swap_ff) |-> path_left_gain_ff == $past(amp_gain_ff[1]))
    else $error("swap did not exchange channels");

endmodule : css_selector_regs

// ### css_host_model.sv
`timescale 1ns/1ps

module css_host_model (
  input wire logic mclk,
  output logic verb_valid,
  output logic [7:0] verb_nid,
  output logic [19:0] verb_word,
  input wire logic resp_valid_ff,
  input wire logic [31:0] resp_data_ff
);

  initial begin
    verb_valid = 1'b0;
    verb_nid = 8'h00;
    verb_word = 20'h0_0000;
  end

  // ------------------------------------------------------------------
  // One verb, held over its taking edge, answer read 1 ns after that same edge
  // ------------------------------------------------------------------
  task automatic send(input logic [7:0] nid, input logic [19:0] word, output logic got, output logic [31:0] data);
    @(posedge mclk);
    #1;
    verb_valid = 1'b1;
    verb_nid = nid;
    verb_word = word;
    @(posedge mclk);
    #1;
    verb_valid = 1'b0;
    // Idle lines carry the inverse so a stale verb can never pass for a fresh one.
    verb_nid = ~nid;
    verb_word = ~word;
    got = resp_valid_ff;
    data = resp_data_ff;
  endtask : send

endmodule : css_host_model

// ### test_css_selector_regs.sv
`timescale 1ns/1ps

module test_css_selector_regs;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  typedef struct {
    logic [7:0] nid;
    logic [19:0] word;
    logic got;
    logic [31:0] data;
  } css_row_t;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] pwr_floor = 2'h0;
  logic verb_valid;
  logic [7:0] verb_nid;
  logic [19:0] verb_word;
  logic resp_valid_ff;
  logic [31:0] resp_data_ff;
  logic [7:0] src_nid_ff;
  logic src_valid_ff;
  logic path_left_mute_ff;
  logic [5:0] path_left_gain_ff;
  logic path_right_mute_ff;
  logic [5:0] path_right_gain_ff;
  logic [1:0] pwr_act_ff;
  logic pwr_busy_ff;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  css_row_t rows [20] = '{
    '{8'h14, 20'hF_0500, 1'b1, 32'h0000_0430},
    '{8'h14, 20'hF_0009, 1'b1, 32'h0030_0D0D},
    '{8'h14, 20'hF_000E, 1'b1, 32'h0000_0005},
    '{8'h14, 20'hF_0200, 1'b1, 32'h0E11_1016},
    '{8'h14, 20'hF_0204, 1'b1, 32'h0000_000F},
    '{8'h14, 20'hF_0012, 1'b1, 32'h8003_2E10},
    '{8'h14, 20'hF_0100, 1'b1, 32'h0000_0000},
    '{8'h14, 20'hF_0C00, 1'b1, 32'h0000_0000},
    '{8'h14, 20'hB_A000, 1'b1, 32'h0000_0090},
    '{8'h14, 20'hB_8000, 1'b1, 32'h0000_0090},
    '{8'h15, 20'hF_0009, 1'b0, 32'h0000_0000},
    '{8'h14, 20'h3_A07F, 1'b1, 32'h0000_0000},
    '{8'h14, 20'hB_A000, 1'b1, 32'h0000_003F},
    '{8'h14, 20'h3_9085, 1'b1, 32'h0000_0000},
    '{8'h14, 20'hB_8000, 1'b1, 32'h0000_0085},
    '{8'h14, 20'h7_0104, 1'b1, 32'h0000_0000},
    '{8'h14, 20'hF_0100, 1'b1, 32'h0000_0004},
    '{8'h14, 20'h7_0C04, 1'b1, 32'h0000_0000},
    '{8'h14, 20'hF_0C00, 1'b1, 32'h0000_0004},
    '{8'h14, 20'hF_0010, 1'b1, 32'h0000_0000}
  };
  logic [7:0] src_tab [8] = '{8'h16, 8'h10, 8'h11, 8'h0E, 8'h0F, 8'h00, 8'h00, 8'h00};
  // Each entry is floor, request and the expected power state word.
  logic [19:0] pwr_tab [4] = '{20'h1_0011, 20'h9_0121, 20'hB_0033, 20'hC_0130};

  always #4 mclk = ~mclk;

  css_selector_regs i_css_selector_regs (
    .mclk(mclk),
    .rst(rst),
    .verb_valid(verb_valid),
    .verb_nid(verb_nid),
    .verb_word(verb_word),
    .pwr_floor(pwr_floor),
    .resp_valid_ff(resp_valid_ff),
    .resp_data_ff(resp_data_ff),
    .src_nid_ff(src_nid_ff),
    .src_valid_ff(src_valid_ff),
    .path_left_mute_ff(path_left_mute_ff),
    .path_left_gain_ff(path_left_gain_ff),
    .path_right_mute_ff(path_right_mute_ff),
    .path_right_gain_ff(path_right_gain_ff),
    .pwr_act_ff(pwr_act_ff),
    .pwr_busy_ff(pwr_busy_ff)
  );

  css_host_model i_css_host_model (
    .mclk(mclk),
    .verb_valid(verb_valid),
    .verb_nid(verb_nid),
    .verb_word(verb_word),
    .resp_valid_ff(resp_valid_ff),
    .resp_data_ff(resp_data_ff)
  );

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic complete_run;
    $display("Comparisons: %0d, mismatches: %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic xfer(input logic [7:0] nid, input logic [19:0] word, input logic got_exp, input logic [31:0] exp);
    logic got;
    logic [31:0] data;
    i_css_host_model.send(nid, word, got, data);
    check("resp_valid", 32'(got), 32'(got_exp));
    check($sformatf("response to %h", word), data, exp);
  endtask : xfer

  task automatic do_reset;
    rst = 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    check("reset outputs", 32'({resp_valid_ff, src_nid_ff, src_valid_ff, path_left_mute_ff, path_left_gain_ff,
      path_right_mute_ff, path_right_gain_ff, pwr_act_ff, pwr_busy_ff}),
      32'({1'b0, 8'h16, 1'b1, 1'b1, 6'h10, 1'b1, 6'h10, 2'h3, 1'b0}));
    rst = 1'b0;
  endtask : do_reset

  // Settling is bounded, so a stuck sequencer shows up as a wrong state, not a hang.
  task automatic wait_idle;
    repeat (4) @(posedge mclk);
    #1;
    for (int n = 0; n < 30 && pwr_busy_ff !== 1'b0; n++) begin
      @(posedge mclk);
      #1;
    end
  endtask : wait_idle

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      complete_run;
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    do_reset;
    foreach (rows[i]) xfer(rows[i].nid, rows[i].word, rows[i].got, rows[i].data);
    // Swap is on here: left path carries the right channel settings.
    check("path left", 32'({path_left_mute_ff, path_left_gain_ff}), 32'h0000_0045);
    check("path right", 32'({path_right_mute_ff, path_right_gain_ff}), 32'h0000_003F);
    xfer(8'h14, 20'h7_0C00, 1'b1, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    #1;
    check("path left", 32'({path_left_mute_ff, path_left_gain_ff}), 32'h0000_003F);
    check("path right", 32'({path_right_mute_ff, path_right_gain_ff}), 32'h0000_0045);
    for (int i = 0; i < 8; i++) begin
      xfer(8'h14, {12'h701, 8'(i)}, 1'b1, 32'h0000_0000);
      @(posedge mclk);
      #1;
      check("src_nid", 32'(src_nid_ff), 32'(src_tab[i]));
      check("src_valid", 32'(src_valid_ff), 32'(i < 5));
    end
    foreach (pwr_tab[i]) begin
      pwr_floor = pwr_tab[i][19:18];
      xfer(8'h14, {12'h705, 6'h00, pwr_tab[i][17:16]}, 1'b1, 32'h0000_0000);
      wait_idle;
      check("pwr_act", 32'(pwr_act_ff), 32'(pwr_tab[i][5:4]));
      xfer(8'h14, 20'hF_0500, 1'b1, {16'h0000, pwr_tab[i][15:0]});
    end
    pwr_floor = 2'h0;
    // First pass clears the lost flag by a read, second pass by a write.
    for (int k = 0; k < 2; k++) begin
      do_reset;
      if (k == 0) begin
        xfer(8'h14, 20'hF_0500, 1'b1, 32'h0000_0430);
      end else begin
        xfer(8'h14, 20'h7_0C00, 1'b1, 32'h0000_0000);
      end
      xfer(8'h14, 20'hF_0500, 1'b1, 32'h0000_0030);
    end
    complete_run;
  end

endmodule : test_css_selector_regs
